// ==== byte_queue.sv ====
`timescale 1ns/100ps
`default_nettype none
module byte_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk, // system clock
  input wire logic i_reset, // sync reset
  input wire logic i_push, // write request
  input wire logic [WIDTH-1:0] i_push_data, // write data
  input wire logic i_pop, // read request
  output logic [WIDTH-1:0] o_head, // oldest entry, registered
  output logic o_empty, // no entries
  output logic o_full // no room
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [WIDTH-1:0] head;
  } queue_state_t;
  queue_state_t s;
  queue_state_t next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push;
  logic do_pop;
  // ***************************************************
  // pointers and prefetched head
  // ***************************************************
  // pushes to a full queue and pops from an empty one are dropped
  always_comb begin
    do_push = i_push && !o_full;
    do_pop = i_pop && !o_empty;
    next_s = s;
    next_s.wr_ptr = AW'(s.wr_ptr + AW'(do_push));
    next_s.rd_ptr = AW'(s.rd_ptr + AW'(do_pop));
    next_s.count = (AW + 1)'(s.count + (AW + 1)'(do_push) - (AW + 1)'(do_pop));
    // bypass so a byte written to the next head slot is seen at once
    if (do_push && s.wr_ptr == next_s.rd_ptr) begin
      next_s.head = i_push_data;
    end else begin
      next_s.head = mem[next_s.rd_ptr];
    end
  end
  assign o_empty = (s.count == '0);
  assign o_full = (s.count == (AW + 1)'(DEPTH));
  assign o_head = s.head;
  // storage has no reset; only pointers, count and head need a defined value
  always_ff @(posedge i_mclk) begin
    if (do_push) begin
      mem[s.wr_ptr] <= i_push_data;
    end
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// ==== isa_dual_serial_port_decode_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module isa_dual_serial_port_decode_tb;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  serial_card_pkg::isa_io_t bus = '0;
  serial_card_pkg::port_cfg_t [1:0] cfg = '0;
  logic [8:0] ext_pd = 9'h000;
  logic [1:0] rxd, sel, txd, rts, den, fac;
  logic [7:0] dout;
  logic doe;
  logic [8:0] irq, irq_oe, pd;
  int miscompares = 0;
  int comparisons = 0;
  logic [9:0] bases [8] = '{10'h280, 10'h2a0, 10'h2e8, 10'h2f8, 10'h3e8, 10'h300, 10'h328,
    10'h3f8};
  // 10 MHz clock
  always begin
    #50 i_mclk = ~i_mclk;
  end
  serial_card #(.QUEUE_DEPTH(16)) i_serial_card (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_bus(bus), .i_port_cfg(cfg), .i_ext_pulldown(ext_pd), .i_rxd(rxd), .o_data(dout),
    .o_data_oe(doe), .o_port_select(sel), .o_irq_line(irq), .o_irq_line_oe(irq_oe),
    .o_irq_pulldown(pd), .o_txd(txd), .o_rts(rts), .o_line_drive_en(den),
    .o_factory_setting(fac));
  line_partner i_line_partner (.i_txd(txd), .o_rxd(rxd));
  // ****
  // bus tasks
  // ****
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge i_mclk);
    #10;
  endtask
  // idle cycle after each strobe so the edge detect sees it drop
  task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
    bus.addr = a;
    bus.data = d;
    bus.iow = 1'b1;
    tick();
    bus.iow = 1'b0;
    tick();
  endtask
  task automatic io_rd(input logic [9:0] a, output logic [7:0] d);
    bus.addr = a;
    bus.ior = 1'b1;
    tick();
    tick();
    d = dout;
    bus.ior = 1'b0;
    tick();
  endtask
  task automatic probe(input logic [9:0] a, input logic aen, input logic [1:0] exp);
    bus.addr = a;
    bus.aen = aen;
    bus.ior = 1'b1;
    tick();
    chk("select", {7'h00, exp}, {7'h00, sel});
    chk("data drive", {8'h00, exp != 2'b00}, {8'h00, doe});
    bus.ior = 1'b0;
    bus.aen = 1'b0;
    tick();
  endtask
  task automatic wait_rx(input logic [9:0] base);
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < 100 && s[0] !== 1'b1; k++) io_rd(base + 10'h5, s);
    chk("rx ready", 9'h001, {8'h00, s[0]});
    if (s[0] !== 1'b1) report_and_stop();
  endtask
  // closed switch stands for a zero address bit
  function automatic logic [7:0] bank(input logic [9:0] b);
    bank[7] = 1'b1;
    for (int n = 0; n < 7; n++) bank[n] = ~b[9-n];
  endfunction
  // ****
  // tests
  // ****
  initial begin
    logic [7:0] d;
    repeat (4) @(posedge i_mclk);
    #10 i_reset = 1'b0;
    foreach (bases[i]) begin
      cfg[0].switches = bank(bases[i]);
      probe(bases[i], 1'b0, 2'b01);
      probe(bases[i] + 10'h7, 1'b0, 2'b01);
      probe(bases[i] + 10'h8, 1'b0, 2'b00);
      probe(bases[i], 1'b1, 2'b00);
      cfg[0].switches[7] = 1'b0;
      probe(bases[i], 1'b0, 2'b00);
    end
    $display("decode test done");
    cfg[0].switches = 8'hfa;
    cfg[1].switches = 8'hba;
    cfg[0].differential = 1'b1;
    cfg[1].differential = 1'b1;
    tick();
    chk("factory", 9'h003, {7'h00, fac});
    io_wr(10'h289, 8'h01);
    io_wr(10'h288, 8'ha5);
    wait_rx(10'h288);
    for (int r = 1; r < 10; r++) begin
      cfg[1].route = serial_card_pkg::irq_route_t'(4'(r));
      tick();
      chk("irq drive", 9'(9'h001 << (r - 1)), irq_oe);
      chk("irq level", 9'(9'h001 << (r - 1)), irq & irq_oe);
    end
    cfg[1].route = serial_card_pkg::ROUTE_IRQ3;
    cfg[1].mode = serial_card_pkg::IRQ_SHARED;
    cfg[0].mode = serial_card_pkg::IRQ_SHARED;
    tick();
    chk("shared silent", 9'h000, irq_oe);
    ext_pd = 9'h002;
    tick();
    chk("shared ext", 9'h002, irq_oe & irq);
    ext_pd = 9'h000;
    cfg[0].route = serial_card_pkg::ROUTE_IRQ3;
    cfg[0].mode = serial_card_pkg::IRQ_SHARED_PULLDOWN;
    tick();
    chk("pull-down", 9'h002, pd);
    chk("shared own", 9'h002, irq_oe & irq);
    cfg[0].route = serial_card_pkg::ROUTE_NONE;
    cfg[1].route = serial_card_pkg::ROUTE_NONE;
    tick();
    chk("no route", 9'h000, irq_oe);
    io_rd(10'h288, d);
    chk("rx data", 9'h0a5, {1'b0, d});
    $display("irq test done");
    cfg[0].rts_driver_ctrl = 1'b1;
    tick();
    chk("driver off", 9'h000, {8'h00, den[0]});
    io_wr(10'h284, 8'h02);
    chk("driver rts", 9'h003, {7'h00, den[0], rts[0]});
    cfg[0].rts_driver_ctrl = 1'b0;
    io_wr(10'h284, 8'h00);
    chk("driver always", 9'h002, {7'h00, den[0], rts[0]});
    $display("driver test done");
    // conventional serial locations with their usual request lines
    cfg[0].switches = bank(10'h3f8);
    cfg[1].switches = bank(10'h2f8);
    cfg[0].route = serial_card_pkg::ROUTE_IRQ4;
    cfg[1].route = serial_card_pkg::ROUTE_IRQ3;
    cfg[0].mode = serial_card_pkg::IRQ_NORMAL;
    cfg[1].mode = serial_card_pkg::IRQ_NORMAL;
    probe(10'h3f8, 1'b0, 2'b01);
    probe(10'h2f8, 1'b0, 2'b10);
    chk("conventional irq", 9'h006, irq_oe);
    $display("conventional test done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== line_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****
// serial line partner: loopback plug on each port
// ****
module line_partner (
  input wire logic [1:0] i_txd, // card transmit
  output logic [1:0] o_rxd // card receive
);
  // per-port loop keeps ports apart; idle high follows txd idle
  assign o_rxd = i_txd;
endmodule
`default_nettype wire

// ==== serial_card.sv ====
`timescale 1ns/100ps
`default_nettype none
module serial_card #(
  parameter int QUEUE_DEPTH = serial_card_pkg::QUEUE_DEPTH
) (
  input wire logic i_mclk, // 10 MHz clock
  input wire logic i_reset, // sync reset, high
  input wire serial_card_pkg::isa_io_t i_bus, // I/O cycle from the slot
  input wire serial_card_pkg::port_cfg_t [1:0] i_port_cfg, // switches and jumpers
  input wire logic [8:0] i_ext_pulldown, // pull-down from another card
  input wire logic [1:0] i_rxd, // serial receive per port
  output logic [7:0] o_data, // read data, registered
  output logic o_data_oe, // drive data bus
  output logic [1:0] o_port_select, // uart chip select
  output logic [8:0] o_irq_line, // request line level
  output logic [8:0] o_irq_line_oe, // request line driven
  output logic [8:0] o_irq_pulldown, // our pull-down on line
  output logic [1:0] o_txd, // serial transmit per port
  output logic [1:0] o_rts, // request to send
  output logic [1:0] o_line_drive_en, // transmitter enable
  output logic [1:0] o_factory_setting // bank at factory value and differential set
);
  typedef struct packed {
    logic [7:0] ier;
    logic [7:0] lcr;
    logic [7:0] mcr;
    logic [15:0] divisor;
    logic [15:0] baud_cnt;
    logic tick;
    serial_card_pkg::line_state_t tx_st;
    logic [3:0] tx_sub;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_par;
    logic tx_stop2;
    logic txd;
    serial_card_pkg::line_state_t rx_st;
    logic [3:0] rx_sub;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic overrun;
    logic framing;
  } uart_t;
  typedef struct packed {
    uart_t [1:0] port;
    logic ior_q;
    logic iow_q;
    logic [7:0] rdata;
  } state_t;
  state_t s;
  state_t next_s;
  logic [1:0] tx_push;
  logic [1:0] tx_pop;
  logic [1:0] tx_empty;
  logic [1:0][7:0] tx_head;
  logic [1:0] rx_push;
  logic [1:0] rx_pop;
  logic [1:0] rx_empty;
  logic [1:0] rx_full;
  logic [1:0][7:0] rx_head;
  logic [1:0][7:0] rx_wdata;
  logic [1:0] uart_irq;
  logic [1:0] cs;
  logic rd_edge;
  logic wr_edge;
  // ***************************************************
  // helpers
  // ***************************************************
  // closed switch reads 1, so the compared address bit is its inverse
  function automatic logic [6:0] base_of(input logic [7:0] sw);
    logic [6:0] b;
    b = '0;
    for (int i = 0; i < 7; i++) begin
      b[6 - i] = ~sw[i];
    end
    return b;
  endfunction
  // route code n maps to request line n-1
  function automatic logic [3:0] line_of(input serial_card_pkg::irq_route_t r);
    return 4'(r - 4'h1);
  endfunction
  // ***************************************************
  // address decode
  // ***************************************************
  // seven-bit compare of A9..A3; A2..A0 choose the register
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      cs[p] = (i_bus.ior || i_bus.iow) && !i_bus.aen
        && i_port_cfg[p].switches[serial_card_pkg::SW_ENABLE]
        && i_bus.addr[9:3] == base_of(i_port_cfg[p].switches);
    end
  end
  assign o_port_select = cs;
  assign rd_edge = i_bus.ior && !s.ior_q;
  assign wr_edge = i_bus.iow && !s.iow_q;
  assign o_data_oe = i_bus.ior && (cs != 2'b00);
  assign o_data = s.rdata;
  // ***************************************************
  // per-port uart: registers, transmitter, receiver
  // ***************************************************
  // both ports run the same logic on separate state and queues
  always_comb begin
    logic [2:0] last_bit;
    logic [7:0] lsr;
    logic tick;
    last_bit = '0;
    lsr = '0;
    tick = 1'b0;
    next_s = s;
    next_s.ior_q = i_bus.ior;
    next_s.iow_q = i_bus.iow;
    tx_push = '0;
    tx_pop = '0;
    rx_push = '0;
    rx_pop = '0;
    rx_wdata = '0;
    uart_irq = '0;
    for (int p = 0; p < 2; p++) begin
      last_bit = 3'({1'b0, s.port[p].lcr[1:0]} + 3'h4);
      lsr = {1'b0, tx_empty[p] && s.port[p].tx_st == serial_card_pkg::LINE_IDLE,
        tx_empty[p], 1'b0, s.port[p].framing, 1'b0, s.port[p].overrun, !rx_empty[p]};
      // 16x oversample tick from the programmable divisor
      tick = s.port[p].tick;
      next_s.port[p].tick = 1'b0;
      next_s.port[p].baud_cnt = 16'(s.port[p].baud_cnt + 16'h1);
      if (s.port[p].baud_cnt + 16'h1 >= s.port[p].divisor) begin
        next_s.port[p].baud_cnt = '0;
        next_s.port[p].tick = 1'b1;
      end
      // register reads; status clears before any same-cycle set below
      if (rd_edge && cs[p]) begin
        unique case (i_bus.addr[2:0])
          serial_card_pkg::REG_DATA: begin
            if (s.port[p].lcr[serial_card_pkg::LCR_DLAB]) begin
              next_s.rdata = s.port[p].divisor[7:0];
            end else begin
              next_s.rdata = rx_head[p];
              rx_pop[p] = 1'b1;
            end
          end
          serial_card_pkg::REG_IER: begin
            next_s.rdata = s.port[p].lcr[serial_card_pkg::LCR_DLAB] ?
              s.port[p].divisor[15:8] : s.port[p].ier;
          end
          serial_card_pkg::REG_IIR: begin
            if (s.port[p].ier[serial_card_pkg::IER_RX] && !rx_empty[p]) begin
              next_s.rdata = serial_card_pkg::IIR_RX;
            end else if (s.port[p].ier[serial_card_pkg::IER_TX] && tx_empty[p]) begin
              next_s.rdata = serial_card_pkg::IIR_TX;
            end else begin
              next_s.rdata = serial_card_pkg::IIR_NONE;
            end
          end
          serial_card_pkg::REG_LCR: next_s.rdata = s.port[p].lcr;
          serial_card_pkg::REG_MCR: next_s.rdata = s.port[p].mcr;
          serial_card_pkg::REG_LSR: begin
            next_s.rdata = lsr;
            next_s.port[p].overrun = 1'b0;
            next_s.port[p].framing = 1'b0;
          end
          default: next_s.rdata = 8'h00;
        endcase
      end
      // register writes
      if (wr_edge && cs[p]) begin
        unique case (i_bus.addr[2:0])
          serial_card_pkg::REG_DATA: begin
            if (s.port[p].lcr[serial_card_pkg::LCR_DLAB]) begin
              next_s.port[p].divisor[7:0] = i_bus.data;
            end else begin
              tx_push[p] = 1'b1;
            end
          end
          serial_card_pkg::REG_IER: begin
            if (s.port[p].lcr[serial_card_pkg::LCR_DLAB]) begin
              next_s.port[p].divisor[15:8] = i_bus.data;
            end else begin
              next_s.port[p].ier = i_bus.data;
            end
          end
          serial_card_pkg::REG_LCR: next_s.port[p].lcr = i_bus.data;
          serial_card_pkg::REG_MCR: next_s.port[p].mcr = i_bus.data;
          default: ;
        endcase
      end
      // transmitter: start, 5..8 data, optional parity, 1 or 2 stop
      if (s.port[p].tx_st == serial_card_pkg::LINE_IDLE) begin
        next_s.port[p].txd = 1'b1;
        if (!tx_empty[p]) begin
          tx_pop[p] = 1'b1;
          next_s.port[p].tx_shift = tx_head[p];
          next_s.port[p].tx_st = serial_card_pkg::LINE_START;
          next_s.port[p].tx_sub = '0;
          next_s.port[p].tx_stop2 = 1'b0;
          next_s.port[p].tx_par = 1'b0;
          next_s.port[p].txd = 1'b0;
        end
      end else if (tick) begin
        next_s.port[p].tx_sub = 4'(s.port[p].tx_sub + 4'h1);
        if (s.port[p].tx_sub == serial_card_pkg::OVERSAMPLE_LAST) begin
          unique case (s.port[p].tx_st)
            serial_card_pkg::LINE_START: begin
              next_s.port[p].tx_st = serial_card_pkg::LINE_DATA;
              next_s.port[p].tx_bit = '0;
              next_s.port[p].txd = s.port[p].tx_shift[0];
            end
            serial_card_pkg::LINE_DATA: begin
              next_s.port[p].tx_par = s.port[p].tx_par ^ s.port[p].tx_shift[0];
              next_s.port[p].tx_shift = {1'b0, s.port[p].tx_shift[7:1]};
              next_s.port[p].tx_bit = 3'(s.port[p].tx_bit + 3'h1);
              next_s.port[p].txd = s.port[p].tx_shift[1];
              if (s.port[p].tx_bit == last_bit) begin
                if (s.port[p].lcr[serial_card_pkg::LCR_PAR_EN]) begin
                  next_s.port[p].tx_st = serial_card_pkg::LINE_PARITY;
                  next_s.port[p].txd = next_s.port[p].tx_par
                    ^ !s.port[p].lcr[serial_card_pkg::LCR_PAR_EVEN];
                end else begin
                  next_s.port[p].tx_st = serial_card_pkg::LINE_STOP;
                  next_s.port[p].txd = 1'b1;
                end
              end
            end
            serial_card_pkg::LINE_PARITY: begin
              next_s.port[p].tx_st = serial_card_pkg::LINE_STOP;
              next_s.port[p].txd = 1'b1;
            end
            serial_card_pkg::LINE_STOP: begin
              if (s.port[p].lcr[serial_card_pkg::LCR_STOP2] && !s.port[p].tx_stop2) begin
                next_s.port[p].tx_stop2 = 1'b1;
              end else begin
                next_s.port[p].tx_st = serial_card_pkg::LINE_IDLE;
              end
            end
            default: next_s.port[p].tx_st = serial_card_pkg::LINE_IDLE;
          endcase
        end
      end
      // receiver: centre of start bit checked, then one sample per bit
      if (tick) begin
        next_s.port[p].rx_sub = 4'(s.port[p].rx_sub + 4'h1);
        unique case (s.port[p].rx_st)
          serial_card_pkg::LINE_IDLE: begin
            next_s.port[p].rx_sub = '0;
            if (!i_rxd[p]) begin
              next_s.port[p].rx_st = serial_card_pkg::LINE_START;
            end
          end
          serial_card_pkg::LINE_START: begin
            if (s.port[p].rx_sub == serial_card_pkg::OVERSAMPLE_MID) begin
              next_s.port[p].rx_sub = '0;
              next_s.port[p].rx_bit = '0;
              next_s.port[p].rx_st = i_rxd[p] ? serial_card_pkg::LINE_IDLE
                : serial_card_pkg::LINE_DATA;
            end
          end
          serial_card_pkg::LINE_DATA: begin
            if (s.port[p].rx_sub == serial_card_pkg::OVERSAMPLE_LAST) begin
              next_s.port[p].rx_shift = {i_rxd[p], s.port[p].rx_shift[7:1]};
              next_s.port[p].rx_bit = 3'(s.port[p].rx_bit + 3'h1);
              if (s.port[p].rx_bit == last_bit) begin
                next_s.port[p].rx_st = s.port[p].lcr[serial_card_pkg::LCR_PAR_EN] ?
                  serial_card_pkg::LINE_PARITY : serial_card_pkg::LINE_STOP;
              end
            end
          end
          serial_card_pkg::LINE_PARITY: begin
            if (s.port[p].rx_sub == serial_card_pkg::OVERSAMPLE_LAST) begin
              next_s.port[p].rx_st = serial_card_pkg::LINE_STOP;
            end
          end
          serial_card_pkg::LINE_STOP: begin
            if (s.port[p].rx_sub == serial_card_pkg::OVERSAMPLE_LAST) begin
              next_s.port[p].rx_st = serial_card_pkg::LINE_IDLE;
              rx_wdata[p] = s.port[p].rx_shift >> (3'h3 - {1'b0, s.port[p].lcr[1:0]});
              // set after the read clear so a new error is never lost
              if (!i_rxd[p]) begin
                next_s.port[p].framing = 1'b1;
              end
              if (rx_full[p]) begin
                next_s.port[p].overrun = 1'b1;
              end else begin
                rx_push[p] = 1'b1;
              end
            end
          end
          default: next_s.port[p].rx_st = serial_card_pkg::LINE_IDLE;
        endcase
      end
      uart_irq[p] = (s.port[p].ier[serial_card_pkg::IER_RX] && !rx_empty[p])
        || (s.port[p].ier[serial_card_pkg::IER_TX] && tx_empty[p]);
    end
  end
  // ***************************************************
  // interrupt routing
  // ***************************************************
  // shared lines idle low through one pull-down; shared ports only ever drive high
  always_comb begin
    logic [3:0] ln;
    logic [8:0] pull_present;
    ln = '0;
    o_irq_pulldown = '0;
    o_irq_line = '0;
    o_irq_line_oe = '0;
    for (int p = 0; p < 2; p++) begin
      if (i_port_cfg[p].route != serial_card_pkg::ROUTE_NONE
          && i_port_cfg[p].mode == serial_card_pkg::IRQ_SHARED_PULLDOWN) begin
        o_irq_pulldown[line_of(i_port_cfg[p].route)] = 1'b1;
      end
    end
    pull_present = o_irq_pulldown | i_ext_pulldown;
    for (int p = 0; p < 2; p++) begin
      ln = line_of(i_port_cfg[p].route);
      // a disabled port keeps quiet even if its jumper is left in place
      if (i_port_cfg[p].route != serial_card_pkg::ROUTE_NONE
          && i_port_cfg[p].switches[serial_card_pkg::SW_ENABLE]) begin
        if (i_port_cfg[p].mode == serial_card_pkg::IRQ_NORMAL) begin
          o_irq_line_oe[ln] = 1'b1;
          o_irq_line[ln] = o_irq_line[ln] | uart_irq[p];
        end else if (uart_irq[p] && pull_present[ln]) begin
          o_irq_line_oe[ln] = 1'b1;
          o_irq_line[ln] = 1'b1;
        end
      end
    end
  end
  // ***************************************************
  // line side outputs
  // ***************************************************
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      o_txd[p] = s.port[p].txd;
      o_rts[p] = s.port[p].mcr[serial_card_pkg::MCR_RTS];
      // rs-232 drivers are never turned off
      o_line_drive_en[p] = !i_port_cfg[p].differential || !i_port_cfg[p].rts_driver_ctrl
        || s.port[p].mcr[serial_card_pkg::MCR_RTS];
    end
    o_factory_setting[0] = i_port_cfg[0].switches == serial_card_pkg::FACTORY_PORT_ONE
      && i_port_cfg[0].differential;
    o_factory_setting[1] = i_port_cfg[1].switches == serial_card_pkg::FACTORY_PORT_TWO
      && i_port_cfg[1].differential;
  end
  // ***************************************************
  // queues
  // ***************************************************
  for (genvar g = 0; g < 2; g++) begin : g_port
    byte_queue #(.WIDTH(8), .DEPTH(QUEUE_DEPTH)) tx_queue (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_push(tx_push[g]),
      .i_push_data(i_bus.data), .i_pop(tx_pop[g]), .o_head(tx_head[g]),
      .o_empty(tx_empty[g]), .o_full());
    byte_queue #(.WIDTH(8), .DEPTH(QUEUE_DEPTH)) rx_queue (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_push(rx_push[g]),
      .i_push_data(rx_wdata[g]), .i_pop(rx_pop[g]), .o_head(rx_head[g]),
      .o_empty(rx_empty[g]), .o_full(rx_full[g]));
  end
  // ***************************************************
  // state register
  // ***************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      s <= '0;
      for (int p = 0; p < 2; p++) begin
        s.port[p].lcr <= serial_card_pkg::LCR_RESET;
        s.port[p].divisor <= serial_card_pkg::DIVISOR_RESET;
        s.port[p].txd <= 1'b1;
      end
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// ==== serial_card_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****
// decode, irq and driver checks
// ****
module serial_card_chk (
  input wire logic i_mclk, // clock
  input wire logic i_reset, // reset
  input wire serial_card_pkg::isa_io_t i_bus, // bus cycle
  input wire serial_card_pkg::port_cfg_t [1:0] i_port_cfg, // config
  input wire logic [8:0] i_ext_pulldown, // other card
  input wire logic [1:0] i_rxd, // rx
  input wire logic [7:0] o_data, // read data
  input wire logic o_data_oe, // data drive
  input wire logic [1:0] o_port_select, // chip select
  input wire logic [8:0] o_irq_line, // irq level
  input wire logic [8:0] o_irq_line_oe, // irq driven
  input wire logic [8:0] o_irq_pulldown, // pull-down
  input wire logic [1:0] o_txd, // tx
  input wire logic [1:0] o_rts, // rts
  input wire logic [1:0] o_line_drive_en, // driver enable
  input wire logic [1:0] o_factory_setting // factory flag
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic [6:0] want;
  logic strobe;
  // address bits a9..a3 that port one's bank asks for
  always_comb begin
    strobe = i_bus.ior | i_bus.iow;
    for (int n = 0; n < 7; n++) begin
      want[6-n] = ~i_port_cfg[0].switches[n];
    end
  end
  property p_cs_aen; i_bus.aen |-> o_port_select == 2'h0; endproperty
  a_cs_aen: assert property (p_cs_aen) else $error("select during dma");
  property p_cs_en; !i_port_cfg[0].switches[7] |-> !o_port_select[0]; endproperty
  a_cs_en: assert property (p_cs_en) else $error("disabled port selected");
  property p_cs_match; o_port_select[0] |-> strobe && i_bus.addr[9:3] == want; endproperty
  a_cs_match: assert property (p_cs_match) else $error("select on wrong address");
  property p_cs_hit;
    strobe && !i_bus.aen && i_port_cfg[0].switches[7] && i_bus.addr[9:3] == want
      |-> o_port_select[0];
  endproperty
  a_cs_hit: assert property (p_cs_hit) else $error("matching address not selected");
  property p_oe; o_data_oe == (i_bus.ior && o_port_select != 2'h0); endproperty
  a_oe: assert property (p_oe) else $error("data drive wrong");
  property p_none;
    i_port_cfg[0].route == serial_card_pkg::ROUTE_NONE &&
      i_port_cfg[1].route == serial_card_pkg::ROUTE_NONE |-> o_irq_line_oe == 9'h000;
  endproperty
  a_none: assert property (p_none) else $error("irq driven with no route");
  property p_silent;
    i_port_cfg[0].mode == serial_card_pkg::IRQ_SHARED && i_ext_pulldown == 9'h000 &&
      i_port_cfg[1].mode == serial_card_pkg::IRQ_SHARED |-> o_irq_line_oe == 9'h000;
  endproperty
  a_silent: assert property (p_silent) else $error("shared irq without pull-down");
  property p_pull;
    i_port_cfg[0].mode != serial_card_pkg::IRQ_SHARED_PULLDOWN &&
      i_port_cfg[1].mode != serial_card_pkg::IRQ_SHARED_PULLDOWN |-> o_irq_pulldown == 9'h000;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-down not asked for");
  property p_drv;
    o_line_drive_en[0] == ((i_port_cfg[0].differential && i_port_cfg[0].rts_driver_ctrl)
      ? o_rts[0] : 1'b1);
  endproperty
  a_drv: assert property (p_drv) else $error("driver enable wrong");
  property p_fact;
    o_factory_setting[0] == (i_port_cfg[0].switches == 8'hfa && i_port_cfg[0].differential);
  endproperty
  a_fact: assert property (p_fact) else $error("factory flag wrong");
  c_sel: cover property (o_port_select[0]);
  c_irq: cover property (o_irq_line_oe != 9'h000);
  c_rts: cover property (o_rts[0]);
endmodule
bind serial_card serial_card_chk i_serial_card_chk (.i_mclk, .i_reset, .i_bus, .i_port_cfg,
  .i_ext_pulldown, .i_rxd, .o_data, .o_data_oe, .o_port_select, .o_irq_line, .o_irq_line_oe,
  .o_irq_pulldown, .o_txd, .o_rts, .o_line_drive_en, .o_factory_setting);
`default_nettype wire

// ==== serial_card_pkg.sv ====
package serial_card_pkg;
  localparam int NPORTS = 2;
  localparam int NIRQ = 9;
  localparam int QUEUE_DEPTH = 16;
  // ***************************************************
  // register locations within a port
  // ***************************************************
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_IER = 3'h1;
  localparam logic [2:0] REG_IIR = 3'h2;
  localparam logic [2:0] REG_LCR = 3'h3;
  localparam logic [2:0] REG_MCR = 3'h4;
  localparam logic [2:0] REG_LSR = 3'h5;
  localparam int LCR_STOP2 = 2;
  localparam int LCR_PAR_EN = 3;
  localparam int LCR_PAR_EVEN = 4;
  localparam int LCR_DLAB = 7;
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int MCR_RTS = 1;
  localparam logic [7:0] IIR_NONE = 8'h01;
  localparam logic [7:0] IIR_TX = 8'h02;
  localparam logic [7:0] IIR_RX = 8'h04;
  localparam logic [7:0] LCR_RESET = 8'h03;
  localparam logic [15:0] DIVISOR_RESET = 16'h0001;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
  localparam int SW_ENABLE = 7;
  // factory switch banks, bit n is position n+1, 1 = closed
  localparam logic [7:0] FACTORY_PORT_ONE = 8'hfa;
  localparam logic [7:0] FACTORY_PORT_TWO = 8'hba;
  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [3:0] {
    ROUTE_NONE = 4'h0, ROUTE_IRQ2_9 = 4'h1, ROUTE_IRQ3 = 4'h2, ROUTE_IRQ4 = 4'h3,
    ROUTE_IRQ5 = 4'h4, ROUTE_IRQ7 = 4'h5, ROUTE_IRQ10 = 4'h6, ROUTE_IRQ11 = 4'h7,
    ROUTE_IRQ12 = 4'h8, ROUTE_IRQ15 = 4'h9
  } irq_route_t;
  typedef enum logic [1:0] {
    IRQ_NORMAL = 2'h0, IRQ_SHARED = 2'h1, IRQ_SHARED_PULLDOWN = 2'h2
  } irq_mode_t;
  typedef enum logic [2:0] {
    LINE_IDLE = 3'b000, LINE_START = 3'b001, LINE_DATA = 3'b011,
    LINE_PARITY = 3'b010, LINE_STOP = 3'b110
  } line_state_t;
  typedef struct packed {
    logic [9:0] addr;
    logic ior;
    logic iow;
    logic aen;
    logic [7:0] data;
  } isa_io_t;
  typedef struct packed {
    logic [7:0] switches;
    irq_route_t route;
    irq_mode_t mode;
    logic rts_driver_ctrl;
    logic differential;
  } port_cfg_t;
endpackage
